// ===== bk_pkg.sv
// constants and types shared by the buck start-up and protection sequencer
package bk_pkg;
   localparam int MCLK_MHZ = 100;
   localparam int MCLK_PERIOD_NS = 10;
   // soft-start slew rates, microvolts per microsecond
   localparam int SLEW_VCC_UV_US = 400;
   localparam int SLEW_FLOAT_UV_US = 200;
   localparam int SLEW_GND_UV_US = 100;
   localparam int UV_PER_MV = 1000;
   // clock cycles spent on each 1 mV step of the ramp
   localparam int STEP_VCC_CYC = UV_PER_MV * MCLK_MHZ / SLEW_VCC_UV_US;
   localparam int STEP_FLOAT_CYC = UV_PER_MV * MCLK_MHZ / SLEW_FLOAT_UV_US;
   localparam int STEP_GND_CYC = UV_PER_MV * MCLK_MHZ / SLEW_GND_UV_US;
   localparam int STEP_W = 10;
   // ramp span in mV: 150 to 750
   localparam logic [9:0] SS_ZERO_MV = 10'h000;
   localparam logic [9:0] SS_START_MV = 10'h096;
   localparam logic [9:0] SS_END_MV = 10'h2EE;
   // valley current sampling window after the set pulse rises
   localparam int SAMPLE_NS = 40;
   localparam int SAMPLE_CYC_RAW = SAMPLE_NS / MCLK_PERIOD_NS;
   localparam int SAMPLE_CYC = (SAMPLE_CYC_RAW < 1) ? 1 : SAMPLE_CYC_RAW;
   // set pulse and low-side steps are in eighths of a period
   localparam int EIGHTHS = 8;
   localparam logic [3:0] LS_STEP_NONE = 4'h0;
   localparam logic [3:0] LS_STEP_FIRST = 4'h1;
   localparam logic [3:0] LS_STEP_LAST = 4'h8;
   localparam logic [3:0] PULSES_PER_STEP_M1 = 4'hF;
   localparam int BLANK_W = 22;
   localparam logic [21:0] BLANK_ZERO = 22'h000000;
   typedef enum logic [1:0] {RATE_GND, RATE_FLOAT, RATE_VCC, RATE_RSVD} rate_t;
   typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_RUN, ST_HICCUP} seq_state_t;
endpackage

// ===== switch_period_timer.sv
// switching period timer with set pulse and current sample window
`timescale 1ns/1ps
module switch_period_timer #(
   parameter int PERIOD_CYCLES = 100,
   parameter int PW = $clog2(PERIOD_CYCLES)
)(
   input wire logic mclk,
   input wire logic rst,
   output logic [PW-1:0] phase,
   output logic period_start,
   output logic set_pulse,
   output logic sample_win
);
   localparam logic [PW-1:0] LAST = PW'(PERIOD_CYCLES - 1);
   localparam logic [PW-1:0] EIGHTH = PW'(PERIOD_CYCLES / bk_pkg::EIGHTHS);
   localparam logic [PW-1:0] SAMPLE = PW'(bk_pkg::SAMPLE_CYC);
   localparam logic [PW-1:0] ZERO = PW'(0);

   logic [PW-1:0] phase_q;
   logic [PW-1:0] phase_d;

   always_comb
   begin
      phase_d = (phase_q == LAST) ? ZERO : phase_q + PW'(1);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         phase_q <= ZERO;
      end
      else
      begin
         phase_q <= phase_d;
      end
   end

   assign phase = phase_q;
   assign period_start = (phase_q == ZERO);
   // main pulse may only begin once the set pulse has fallen
   assign set_pulse = (phase_q < EIGHTH); // RL10
   assign sample_win = (phase_q < SAMPLE); // RL10

   property p_timer_wrap;
      @(posedge mclk) disable iff (rst)
      (phase_q == LAST) |=> (phase_q == ZERO);
   endproperty
   a_timer_wrap: assert property (p_timer_wrap) // RL10
      else $error("period counter failed to wrap");
endmodule

// ===== buck_startup_protect_sequencer.sv
// start-up, pre-bias and hiccup sequencer for a synchronous buck stage
// Notes on behaviour
// RL1: ramp starts only when enable, bias supply and supplies-valid are all good.
// RL2: rate pin picks slew 0.4, 0.2 or 0.1 mV/us.
// RL3: ramp runs from 150 mV to 750 mV at the chosen slew.
// RL4: overcurrent and overvoltage guards stay live during the ramp.
// RL5: low side stays off until the first high-side pulse, except while the overvoltage latch is set.
// RL6: low side starts at one eighth of period, rising by eighths.
// RL7: each low-side duty step lasts 16 switching pulses, eight steps at most.
// RL8: regulation flag stays low until the first high-side pulse.
// RL9: enable low shuts down and drives both gates low.
// RL10: current sampled 40 ns after set rise; main pulse starts at set fall.
// RL11: overcurrent enters hiccup, drops regulation flag, zeroes soft-start level.
// RL12: hiccup keeps blanking and retrying while the overload stays.
// RL13: hiccup blanking length follows the rate pin setting.
// RL14: after blanking, ramp restarts from its start level with pre-bias rearmed.
`timescale 1ns/1ps
module buck_startup_protect_sequencer #(
   parameter int PERIOD_CYCLES = 100,
   parameter int BLANK_VCC_CYC = 300000,
   parameter int BLANK_FLOAT_CYC = 600000,
   parameter int BLANK_GND_CYC = 1200000
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable_ok,
   input wire logic bias_ok,
   input wire logic supplies_valid,
   input wire bk_pkg::rate_t rate_select,
   input wire logic hs_demand,
   input wire logic overcurrent_cmp,
   input wire logic overvoltage_cmp,
   input wire logic fb_in_window,
   output logic high_side_switch,
   output logic low_side_switch,
   output logic output_in_regulation_flag,
   output logic hiccup_active,
   output logic [9:0] soft_start_mv
);
   localparam int PW = $clog2(PERIOD_CYCLES);
   localparam logic [PW:0] EIGHTH = (PW+1)'(PERIOD_CYCLES / bk_pkg::EIGHTHS);

   // cycles per 1 mV ramp step for the selected slew; unknown code runs slowest
   function automatic logic [9:0] step_cycles(input bk_pkg::rate_t r);
      case (r)
         bk_pkg::RATE_VCC: step_cycles = 10'(bk_pkg::STEP_VCC_CYC);
         bk_pkg::RATE_FLOAT: step_cycles = 10'(bk_pkg::STEP_FLOAT_CYC);
         default: step_cycles = 10'(bk_pkg::STEP_GND_CYC);
      endcase
   endfunction

   function automatic logic [21:0] blank_cycles(input bk_pkg::rate_t r);
      case (r)
         bk_pkg::RATE_VCC: blank_cycles = 22'(BLANK_VCC_CYC);
         bk_pkg::RATE_FLOAT: blank_cycles = 22'(BLANK_FLOAT_CYC);
         default: blank_cycles = 22'(BLANK_GND_CYC);
      endcase
   endfunction

   logic [PW-1:0] phase;
   logic period_start;
   logic set_pulse;
   logic sample_win;

   switch_period_timer #(.PERIOD_CYCLES(PERIOD_CYCLES), .PW(PW)) u_timer (
      .mclk(mclk),
      .rst(rst),
      .phase(phase),
      .period_start(period_start),
      .set_pulse(set_pulse),
      .sample_win(sample_win)
   );

   bk_pkg::seq_state_t state_q, state_d;
   logic [9:0] ss_q, ss_d;
   logic [9:0] step_cnt_q, step_cnt_d;
   logic [21:0] blank_q, blank_d;
   logic first_hs_q, first_hs_d;
   logic [3:0] ls_step_q, ls_step_d;
   logic [3:0] pulse_cnt_q, pulse_cnt_d;
   logic ov_q, ov_d;
   logic hs_q, hs_d;
   logic ls_q, ls_d;
   logic pg_q, pg_d;
   logic hiccup_q, hiccup_d;
   logic count_arm_q, count_arm_d;
   logic start_ok;
   logic active;
   logic oc_trip;
   logic [PW:0] ls_limit;

   assign start_ok = enable_ok && bias_ok && supplies_valid; // RL1
   assign active = (state_q == bk_pkg::ST_RAMP) || (state_q == bk_pkg::ST_RUN);
   // guard is live in ramp as well as run
   assign oc_trip = active && sample_win && overcurrent_cmp; // RL4 RL10
   assign ls_limit = (PW+1)'(ls_step_q) * EIGHTH; // RL6

   always_comb
   begin
      state_d = state_q;
      ss_d = ss_q;
      step_cnt_d = step_cnt_q;
      blank_d = blank_q;
      first_hs_d = first_hs_q;
      ls_step_d = ls_step_q;
      pulse_cnt_d = pulse_cnt_q;
      count_arm_d = count_arm_q;
      ov_d = ov_q;
      // overvoltage latch holds the high side off until enable is cycled
      if (!enable_ok)
      begin
         ov_d = 1'b0;
      end
      else if (active && overvoltage_cmp)
      begin
         ov_d = 1'b1; // RL4
      end
      case (state_q)
         bk_pkg::ST_OFF:
         begin
            if (start_ok)
            begin
               state_d = bk_pkg::ST_RAMP; // RL1
               ss_d = bk_pkg::SS_START_MV;
               step_cnt_d = 10'h000;
            end
         end
         bk_pkg::ST_RAMP:
         begin
            if (step_cnt_q == step_cycles(rate_select) - 10'h001) // RL2
            begin
               step_cnt_d = 10'h000;
               if (ss_q == bk_pkg::SS_END_MV)
               begin
                  state_d = bk_pkg::ST_RUN; // RL3
               end
               else
               begin
                  ss_d = ss_q + 10'h001; // RL3
               end
            end
            else
            begin
               step_cnt_d = step_cnt_q + 10'h001;
            end
         end
         bk_pkg::ST_RUN:
         begin
            state_d = bk_pkg::ST_RUN;
         end
         bk_pkg::ST_HICCUP:
         begin
            if (blank_q != bk_pkg::BLANK_ZERO)
            begin
               blank_d = blank_q - 22'h000001; // RL12
            end
            else if (start_ok)
            begin
               // full restart; a persisting short trips again on the ramp
               state_d = bk_pkg::ST_RAMP; // RL14 RL12
               ss_d = bk_pkg::SS_START_MV;
               step_cnt_d = 10'h000;
            end
         end
         default:
         begin
            state_d = bk_pkg::ST_OFF;
         end
      endcase

      hs_d = active && start_ok && !ov_q && !overvoltage_cmp && !oc_trip
         && !set_pulse && hs_demand; // RL10
      if (hs_d && !first_hs_q)
      begin
         first_hs_d = 1'b1; // RL5
         ls_step_d = bk_pkg::LS_STEP_FIRST; // RL6
         pulse_cnt_d = 4'h0;
         count_arm_d = 1'b0;
      end
      else if (first_hs_q && period_start
         && ls_step_q != bk_pkg::LS_STEP_LAST)
      begin
         if (!count_arm_q)
         begin
            // period of the first high-side pulse had no low-side pulse
            count_arm_d = 1'b1; // RL7
         end
         else if (pulse_cnt_q == bk_pkg::PULSES_PER_STEP_M1)
         begin
            pulse_cnt_d = 4'h0;
            ls_step_d = ls_step_q + 4'h1; // RL7 RL6
         end
         else
         begin
            pulse_cnt_d = pulse_cnt_q + 4'h1; // RL7
         end
      end

      if (ov_q)
      begin
         // low side discharges the output only while it is still high
         ls_d = enable_ok && overvoltage_cmp; // RL9
      end
      else
      begin
         ls_d = active && start_ok && first_hs_q && !hs_d && !oc_trip
            && ({1'b0, phase} < ls_limit); // RL5 RL6
      end
      pg_d = (state_q == bk_pkg::ST_RUN) && start_ok && first_hs_q
         && fb_in_window && !ov_q && !oc_trip; // RL8

      if (oc_trip)
      begin
         state_d = bk_pkg::ST_HICCUP; // RL11
         ss_d = bk_pkg::SS_ZERO_MV; // RL11
         blank_d = blank_cycles(rate_select); // RL13
         first_hs_d = 1'b0; // RL14
         count_arm_d = 1'b0;
         ls_step_d = bk_pkg::LS_STEP_NONE;
         pulse_cnt_d = 4'h0;
      end
      if (!start_ok)
      begin
         state_d = bk_pkg::ST_OFF; // RL9
         ss_d = bk_pkg::SS_ZERO_MV;
         blank_d = bk_pkg::BLANK_ZERO;
         first_hs_d = 1'b0;
         ls_step_d = bk_pkg::LS_STEP_NONE;
         pulse_cnt_d = 4'h0;
         count_arm_d = 1'b0;
      end
      hiccup_d = (state_d == bk_pkg::ST_HICCUP); // RL12
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= bk_pkg::ST_OFF;
         ss_q <= bk_pkg::SS_ZERO_MV;
         step_cnt_q <= 10'h000;
         blank_q <= bk_pkg::BLANK_ZERO;
         first_hs_q <= 1'b0;
         ls_step_q <= bk_pkg::LS_STEP_NONE;
         pulse_cnt_q <= 4'h0;
         ov_q <= 1'b0;
         hs_q <= 1'b0;
         ls_q <= 1'b0;
         pg_q <= 1'b0;
         hiccup_q <= 1'b0;
         count_arm_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ss_q <= ss_d;
         step_cnt_q <= step_cnt_d;
         blank_q <= blank_d;
         first_hs_q <= first_hs_d;
         ls_step_q <= ls_step_d;
         pulse_cnt_q <= pulse_cnt_d;
         ov_q <= ov_d;
         hs_q <= hs_d;
         ls_q <= ls_d;
         pg_q <= pg_d;
         hiccup_q <= hiccup_d;
         count_arm_q <= count_arm_d;
      end
   end

   assign high_side_switch = hs_q;
   assign low_side_switch = ls_q;
   assign output_in_regulation_flag = pg_q;
   assign hiccup_active = hiccup_q;
   assign soft_start_mv = ss_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_no_start;
      !start_ok |=> (ss_q == bk_pkg::SS_ZERO_MV) && !high_side_switch;
   endproperty
   a_no_start: assert property (p_no_start) // RL1
      else $error("ramp or drive without valid supplies");

   property p_slew_step;
      (state_q == bk_pkg::ST_RAMP && $past(state_q) == bk_pkg::ST_RAMP
         && $changed(ss_q))
      |-> ($past(step_cnt_q) == step_cycles($past(rate_select)) - 10'h001);
   endproperty
   a_slew_step: assert property (p_slew_step) // RL2
      else $error("ramp step taken at wrong interval");

   property p_ramp_span;
      (state_q == bk_pkg::ST_RAMP) |->
         (ss_q >= bk_pkg::SS_START_MV) && (ss_q <= bk_pkg::SS_END_MV);
   endproperty
   a_ramp_span: assert property (p_ramp_span) // RL3
      else $error("soft-start level outside ramp span");

   property p_oc_in_ramp;
      (state_q == bk_pkg::ST_RAMP && oc_trip && start_ok)
         |=> (state_q == bk_pkg::ST_HICCUP);
   endproperty
   a_oc_in_ramp: assert property (p_oc_in_ramp) // RL4
      else $error("overcurrent during ramp ignored");

   property p_prebias_ls_off;
      (!first_hs_q && !ov_q) |=> !low_side_switch;
   endproperty
   a_prebias_ls_off: assert property (p_prebias_ls_off) // RL5
      else $error("low side on before first high-side pulse");

   property p_ls_step_range;
      first_hs_q |-> (ls_step_q >= bk_pkg::LS_STEP_FIRST)
         && (ls_step_q <= bk_pkg::LS_STEP_LAST);
   endproperty
   a_ls_step_range: assert property (p_ls_step_range) // RL6
      else $error("low-side step out of range");

   property p_ls_step_hold;
      ($changed(ls_step_q) && $past(ls_step_q) != bk_pkg::LS_STEP_NONE
         && ls_step_q != bk_pkg::LS_STEP_NONE)
      |-> ($past(pulse_cnt_q) == bk_pkg::PULSES_PER_STEP_M1)
         && $past(period_start);
   endproperty
   a_ls_step_hold: assert property (p_ls_step_hold) // RL7
      else $error("low-side step advanced before 16 pulses");

   property p_pg_prebias;
      !first_hs_q |=> !output_in_regulation_flag;
   endproperty
   a_pg_prebias: assert property (p_pg_prebias) // RL8
      else $error("regulation flag before first high-side pulse");

   property p_shutdown;
      !enable_ok |=> !high_side_switch && !low_side_switch;
   endproperty
   a_shutdown: assert property (p_shutdown) // RL9
      else $error("gate driven while enable low");

   property p_set_gap;
      set_pulse |=> !high_side_switch;
   endproperty
   a_set_gap: assert property (p_set_gap) // RL10
      else $error("high side on during set pulse");

   property p_hiccup_entry;
      (oc_trip && start_ok) |=> hiccup_active && !output_in_regulation_flag
         && (soft_start_mv == bk_pkg::SS_ZERO_MV);
   endproperty
   a_hiccup_entry: assert property (p_hiccup_entry) // RL11
      else $error("overcurrent did not enter hiccup cleanly");

   property p_blank_hold;
      (hiccup_active && blank_q != bk_pkg::BLANK_ZERO && start_ok)
         |=> hiccup_active;
   endproperty
   a_blank_hold: assert property (p_blank_hold) // RL12
      else $error("hiccup left before blanking expired");

   property p_blank_len;
      (oc_trip && start_ok) |=> (blank_q == blank_cycles($past(rate_select)));
   endproperty
   a_blank_len: assert property (p_blank_len) // RL13
      else $error("blanking length does not match rate setting");

   property p_restart;
      (hiccup_active && blank_q == bk_pkg::BLANK_ZERO && start_ok)
      |=> (state_q == bk_pkg::ST_RAMP) && (ss_q == bk_pkg::SS_START_MV)
         && !first_hs_q;
   endproperty
   a_restart: assert property (p_restart) // RL14
      else $error("restart after blanking not from start level");
endmodule

// ===== power_stage_model.sv
// power stage model: gate drivers, valley sense and feedback comparators
`timescale 1ns/1ps
module power_stage_model (
   input wire logic mclk,
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   input wire logic overload,
   input wire logic over_volt,
   input wire logic in_window,
   output logic overcurrent_cmp,
   output logic overvoltage_cmp,
   output logic fb_in_window,
   output int shoot_through
);
   // comparators are plain levels; the sequencer owns the sample window
   assign overcurrent_cmp = overload;
   assign overvoltage_cmp = over_volt;
   assign fb_in_window = in_window;
   // both switches on together would short the input rail
   int overlap_cnt = 0;
   assign shoot_through = overlap_cnt;
   always @(posedge mclk)
      if (high_side_switch && low_side_switch)
         overlap_cnt <= overlap_cnt + 1;
endmodule

// ===== buck_startup_protect_sequencer_tb.sv
// self-checking bench for the buck start-up and protection sequencer
`timescale 1ns/1ps
module buck_startup_protect_sequencer_tb;
   // short period and blanking keep the run well under the cycle budget
   localparam int PERIOD = 16;
   localparam int BV = 20;
   localparam int BF = 40;
   localparam int BG = 80;
   logic mclk, rst, enable_ok, bias_ok, supplies_valid, hs_demand;
   bk_pkg::rate_t rate_select;
   logic overcurrent_cmp, overvoltage_cmp, fb_in_window;
   logic high_side_switch, low_side_switch, output_in_regulation_flag;
   logic hiccup_active, overload, over_volt, in_window;
   logic [9:0] soft_start_mv;
   logic [31:0] seed;
   int shoot_through, mismatches, checks_done, n, k, w, v, run, prev;
   int d[3];
   buck_startup_protect_sequencer #(.PERIOD_CYCLES(PERIOD),
      .BLANK_VCC_CYC(BV), .BLANK_FLOAT_CYC(BF), .BLANK_GND_CYC(BG)) u_dut (
      .mclk, .rst, .enable_ok, .bias_ok, .supplies_valid, .rate_select,
      .hs_demand, .overcurrent_cmp, .overvoltage_cmp, .fb_in_window,
      .high_side_switch, .low_side_switch, .output_in_regulation_flag,
      .hiccup_active, .soft_start_mv);
   power_stage_model u_stage (.mclk, .high_side_switch, .low_side_switch,
      .overload, .over_volt, .in_window, .overcurrent_cmp, .overvoltage_cmp,
      .fb_in_window, .shoot_through);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic int step_cyc(input bk_pkg::rate_t r);
      if (r == bk_pkg::RATE_VCC)
         return bk_pkg::STEP_VCC_CYC;
      return r == bk_pkg::RATE_FLOAT ? bk_pkg::STEP_FLOAT_CYC :
         bk_pkg::STEP_GND_CYC;
   endfunction
   function automatic logic sig(input int s);
      return s == 0 ? high_side_switch :
         s == 1 ? low_side_switch : hiccup_active;
   endfunction
   task automatic tick(input int c = 1);
      repeat (c) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (e !== g)
      begin
         mismatches++;
         $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // bounded wait on high side (0), low side (1) or hiccup (2)
   task automatic wait_lvl(input int s, input logic val, input int lim);
      n = 0;
      while (sig(s) !== val && n < lim)
      begin
         tick();
         n++;
      end
      if (sig(s) !== val)
      begin
         chk("awaited output", val, sig(s));
         complete_run();
      end
   endtask
   task automatic power(input logic on);
      {enable_ok, bias_ok, supplies_valid} = {3{on}};
      tick();
   endtask
   initial
   begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      rst = 1;
      {enable_ok, bias_ok, supplies_valid, hs_demand} = 4'h0;
      {overload, over_volt, in_window} = 3'h0;
      rate_select = bk_pkg::RATE_VCC;
      seed = 32'h000056C1;
      mismatches = 0;
      checks_done = 0;
      tick(3);
      rst = 0;
      chk("soft_start_mv", 0, soft_start_mv);
      for (k = 0; k < 7; k++)
      begin
         {enable_ok, bias_ok, supplies_valid} = 3'(k);
         tick(2);
         chk("soft_start_mv", 0, soft_start_mv);
      end
      for (k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         in_window = seed[2];
         rate_select = bk_pkg::rate_t'(k);
         power(0);
         tick(1 + int'(seed[1:0]));
         power(1);
         chk("ramp start", bk_pkg::SS_START_MV, soft_start_mv);
         n = 0;
         while (soft_start_mv === bk_pkg::SS_START_MV && n < 1200)
         begin
            tick();
            n++;
         end
         chk("ramp step cycles", step_cyc(rate_select), n);
         if (n == 1200)
            complete_run();
         chk("ramp next level", 151, soft_start_mv);
         enable_ok = 0;
         tick();
         chk("soft_start_mv", 0, soft_start_mv);
      end
      rate_select = bk_pkg::RATE_VCC;
      in_window = 1;
      power(0);
      power(1);
      for (k = 0; k < 40; k++)
      begin
         chk("low_side_switch", 0, low_side_switch);
         chk("regulation flag", 0, output_in_regulation_flag);
         tick();
      end
      hs_demand = 1;
      wait_lvl(0, 1, 3 * PERIOD);
      hs_demand = 0;
      wait_lvl(1, 1, 3 * PERIOD);
      prev = 0;
      run = 0;
      // one window per period, aligned to the first low-side rise
      for (w = 0; w < 130; w++)
      begin
         v = 0;
         for (k = 0; k < PERIOD; k++)
         begin
            v += int'(low_side_switch);
            tick();
         end
         if (w == 0)
            chk("first low side width", 2, v);
         else if (v != prev)
         begin
            chk("low side width step", prev + 2, v);
            chk("periods per step", 16, run);
            run = 0;
         end
         run++;
         prev = v;
      end
      chk("final low side width", PERIOD, prev);
      hs_demand = 1;
      wait_lvl(0, 1, 3 * PERIOD);
      wait_lvl(0, 0, 3 * PERIOD);
      for (w = 0; w < 3; w++)
      begin
         v = 0;
         for (k = 0; k < PERIOD; k++)
         begin
            v += int'(!high_side_switch);
            tick();
         end
         chk("high side off per period", 2, v);
      end
      // one-cycle overload at each phase; only the sample window trips
      prev = 0;
      for (k = 0; k < PERIOD; k++)
      begin
         wait_lvl(0, 1, 200);
         wait_lvl(0, 0, 3 * PERIOD);
         tick(k);
         overload = 1;
         tick();
         overload = 0;
         if (hiccup_active === 1'b1)
         begin
            prev++;
            chk("soft_start_mv", 0, soft_start_mv);
            chk("high_side_switch", 0, high_side_switch);
            chk("regulation flag", 0, output_in_regulation_flag);
         end
      end
      chk("tripping phases", bk_pkg::SAMPLE_CYC, prev);
      overload = 1;
      wait_lvl(2, 1, 300);
      for (k = 0; k < 3; k++)
      begin
         rate_select = bk_pkg::rate_t'(k);
         wait_lvl(2, 0, 300);
         chk("restart level", bk_pkg::SS_START_MV, soft_start_mv);
         chk("low_side_switch", 0, low_side_switch);
         wait_lvl(2, 1, PERIOD + 4);
         d[k] = 0;
         while (hiccup_active === 1'b1 && d[k] < 300)
         begin
            tick();
            d[k]++;
         end
         if (d[k] == 300)
         begin
            mismatches++;
            complete_run();
         end
      end
      chk("float minus vcc blanking", BF - BV, d[1] - d[2]);
      chk("gnd minus float blanking", BG - BF, d[0] - d[1]);
      overload = 0;
      wait_lvl(2, 0, 300);
      tick(3 * PERIOD);
      chk("hiccup_active", 0, hiccup_active);
      over_volt = 1;
      tick(3);
      chk("high side in overvoltage", 0, high_side_switch);
      chk("low side in overvoltage", 1, low_side_switch);
      over_volt = 0;
      v = 0;
      for (k = 0; k < 2 * PERIOD; k++)
      begin
         tick();
         v += int'(high_side_switch);
      end
      chk("latched high side pulses", 0, v);
      enable_ok = 0;
      tick(2);
      chk("high_side_switch", 0, high_side_switch);
      chk("low_side_switch", 0, low_side_switch);
      chk("soft_start_mv", 0, soft_start_mv);
      enable_ok = 1;
      wait_lvl(0, 1, 4 * PERIOD);
      chk("shoot through cycles", 0, shoot_through);
      complete_run();
   end
endmodule
